// >>> dps_defines.svh
// Timing counts and widths for the pulse self-refresh controller
`ifndef DPS_DEFINES_SVH
`define DPS_DEFINES_SVH

`define DPS_CLK_NS 25
`define DPS_ADDR_W 10
`define DPS_WAIT_W 8

// Self-refresh cycle maximum at the hottest rating, and the period actually used
`define DPS_SR_CYC_MAX_NS 5000
`define DPS_SR_CYC_MAX_CNT (`DPS_SR_CYC_MAX_NS / `DPS_CLK_NS)
`define DPS_SR_PERIOD_NS 4000
`define DPS_SR_PERIOD_CNT (`DPS_SR_PERIOD_NS / `DPS_CLK_NS)

// Row strobe low time of a refresh pulse (least time, rounded up)
`define DPS_RAS_LOW_NS 600
`define DPS_RAS_LOW_CNT ((`DPS_RAS_LOW_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)

// Average CAS-before-RAS spacing in normal operation (longest time, rounded down)
`define DPS_REF_INT_NS 62000
`define DPS_REF_INT_CNT (`DPS_REF_INT_NS / `DPS_CLK_NS)

// Device entry delay before true self-refresh
`define DPS_ENTRY_DLY_NS 2500000
`define DPS_ENTRY_DLY_CNT (`DPS_ENTRY_DLY_NS / `DPS_CLK_NS)

// Access and precharge phases (least times, rounded up)
`define DPS_RCD_NS 500
`define DPS_RCD_CNT ((`DPS_RCD_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`define DPS_CAS_NS 150
`define DPS_CAS_CNT ((`DPS_CAS_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`define DPS_PRE_NS 500
`define DPS_PRE_CNT ((`DPS_PRE_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`define DPS_CSR_NS 50
`define DPS_CSR_CNT ((`DPS_CSR_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)

`endif

// >>> dps_pkg.sv
// Types shared by the pulse self-refresh controller
package dps_pkg;
   typedef enum logic [3:0]
   {
      st_idle = 4'h0,
      st_acc_row = 4'h1,
      st_acc_col = 4'h2,
      st_cbr_cas = 4'h3,
      st_cbr_ras = 4'h4,
      st_precharge = 4'h5,
      st_sr_low = 4'h6,
      st_sr_high = 4'h7
   } dps_state_t;
endpackage

// >>> dps_interval.sv
// Free interval timer giving a one-cycle tick every PERIOD cycles
`timescale 1ns/1ps
module dps_interval
   import dps_pkg::*;
#(
   parameter int PERIOD = 2480
)
(
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_restart,
   output logic o_tick
);
   localparam int W = $clog2(PERIOD + 1);
   localparam logic [W-1:0] LAST = W'(PERIOD - 1);

   logic [W-1:0] count;
   wire at_last = (count == LAST);

   // Counter restarts from zero so the next tick is a full period away
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst || i_restart || at_last)
         count <= '0;
      else
         count <= count + W'(1);
   end

   // Tick stays out of restart cycles
   assign o_tick = at_last && !i_restart && !i_sys_rst;
endmodule // dps_interval

// >>> dps_ctrl.sv
// Host controller driving a pulse self-refresh DRAM through its pins
// Summary of operation
// R1 - Enter self-refresh: pull request low and start slow row strobe pulses.
// R2 - Device runs self-refresh while request is low; most circuits idle.
// R3 - Device refreshes one row per nineteen row strobe clocks in self-refresh.
// R4 - Request low stops device oscillator and resets its strobe buffer and divider.
// R5 - Device waits 2.5 ms after request falls before true self-refresh.
// R6 - Keep pulsing row strobe throughout self-refresh to retain data.
// R7 - In long normal operation issue CAS-before-RAS refresh about every 62 us.
// R8 - Device takes CBR row address from its own counter; no address needed.
// R9 - CBR and self-refresh rows advance one shared internal row counter.
// R10 - No extra CBR burst is needed before self-refresh entry.
// R11 - Last self-refresh fall to first CBR fall stays within cycle maximum.
// R12 - After exit, issue CBR before 5 us of normal accesses pass.
// R13 - Last CBR fall to first self-refresh fall stays within cycle maximum.
// R14 - RAS-only refresh does not advance the device row counter.
// R15 - Non-CBR refresh would need 512-cycle bursts around self-refresh.
// R16 - Use CAS-before-RAS for normal refresh when self-refresh is used.
// R17 - Device has no error checking; any protection lives outside it.
// R18 - Raise request before the first CBR or access after exit.
`timescale 1ns/1ps
`include "dps_defines.svh"
module dps_ctrl
   import dps_pkg::*;
#(
   parameter int ENTRY_DLY_CNT = `DPS_ENTRY_DLY_CNT
)
(
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_sleep_req,
   input wire logic i_acc_req,
   input wire logic i_acc_we,
   input wire logic [`DPS_ADDR_W-1:0] i_acc_row,
   input wire logic [`DPS_ADDR_W-1:0] i_acc_col,
   input wire logic i_acc_wdata,
   input wire logic i_dout,
   output logic o_acc_ready,
   output logic o_acc_done,
   output logic o_acc_rdata,
   output logic o_sr_active,
   output logic o_sr_settled,
   output logic o_ras_n,
   output logic o_cas_n,
   output logic o_we_n,
   output logic [`DPS_ADDR_W-1:0] o_addr,
   output logic o_din,
   output logic o_self_refresh_request_n
);
   localparam logic [`DPS_WAIT_W-1:0] W_RCD = `DPS_WAIT_W'(`DPS_RCD_CNT - 1);
   localparam logic [`DPS_WAIT_W-1:0] W_CAS = `DPS_WAIT_W'(`DPS_CAS_CNT - 1);
   localparam logic [`DPS_WAIT_W-1:0] W_PRE = `DPS_WAIT_W'(`DPS_PRE_CNT - 1);
   localparam logic [`DPS_WAIT_W-1:0] W_CSR = `DPS_WAIT_W'(`DPS_CSR_CNT - 1);
   localparam logic [`DPS_WAIT_W-1:0] W_LOW = `DPS_WAIT_W'(`DPS_RAS_LOW_CNT - 1);
   localparam logic [`DPS_WAIT_W-1:0] W_HIGH =
      `DPS_WAIT_W'(`DPS_SR_PERIOD_CNT - `DPS_RAS_LOW_CNT - 1);

   dps_state_t state;
   dps_state_t next_state;
   logic [`DPS_WAIT_W-1:0] wcnt;
   logic [`DPS_WAIT_W-1:0] wait_load;
   logic ref_due;
   logic exit_pending;
   logic enter_pending;
   logic sr_mode;
   logic acc_we;
   logic [`DPS_ADDR_W-1:0] acc_col;
   logic acc_wdata;
   logic ref_tick;
   logic settle_tick;

   // Phase decode
   wire wait_done = (wcnt == '0);
   wire moving = (next_state != state);
   wire cbr_start = (next_state == st_cbr_cas) && moving;
   wire want_sleep = i_sleep_req && !sr_mode;
   wire accept = o_acc_ready && i_acc_req;
   wire acc_end = (state == st_acc_col) && wait_done;
   wire sr_stay = i_sleep_req;
   wire ras_low_next = (next_state == st_acc_row) || (next_state == st_acc_col) ||
                       (next_state == st_cbr_ras) || (next_state == st_sr_low);
   wire cas_low_next = (next_state == st_acc_col) || (next_state == st_cbr_cas) ||
                       (next_state == st_cbr_ras);

   // Access refused while any refresh duty is owed, so refresh never starves
   assign o_acc_ready = (state == st_idle) && !ref_due && !exit_pending && !want_sleep;
   assign o_sr_active = sr_mode;

   // Next state; refresh duty outranks sleep, sleep outranks access
   always_comb
   begin
      next_state = state;
      unique case (state)
         st_idle:
            if (ref_due || exit_pending || want_sleep)
               next_state = st_cbr_cas; // R16 R15 R14
            else if (i_acc_req)
               next_state = st_acc_row;
         st_acc_row:
            if (wait_done)
               next_state = st_acc_col;
         st_acc_col:
            if (wait_done)
               next_state = st_precharge;
         st_cbr_cas:
            if (wait_done)
               next_state = st_cbr_ras;
         st_cbr_ras:
            if (wait_done)
               next_state = st_precharge;
         st_precharge:
            if (wait_done)
               next_state = enter_pending ? st_sr_low : st_idle; // R13
         st_sr_low:
            if (wait_done)
               next_state = st_sr_high; // R6
         st_sr_high:
            if (wait_done)
               next_state = sr_stay ? st_sr_low : st_idle; // R6 R11
      endcase
   end

   // Duration of the phase being entered
   always_comb
   begin
      wait_load = '0;
      unique case (next_state)
         st_idle: wait_load = '0;
         st_acc_row: wait_load = W_RCD;
         st_acc_col: wait_load = W_CAS;
         st_cbr_cas: wait_load = W_CSR;
         st_cbr_ras: wait_load = W_LOW;
         st_precharge: wait_load = W_PRE;
         st_sr_low: wait_load = W_LOW;
         st_sr_high: wait_load = W_HIGH;
      endcase
   end

   // State and phase timer
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         state <= st_idle;
         wcnt <= '0;
      end
      else
      begin
         state <= next_state;
         wcnt <= moving ? wait_load : (wait_done ? wcnt : wcnt - `DPS_WAIT_W'(1));
      end
   end

   // Refresh duty flags; a tick in the clearing cycle still sets the flag
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         ref_due <= 1'b0;
         enter_pending <= 1'b0;
         exit_pending <= 1'b0;
      end
      else
      begin
         ref_due <= ref_tick || (ref_due && !cbr_start); // R7
         // One CBR right before entry is enough, no burst
         if (cbr_start && want_sleep)
            enter_pending <= 1'b1; // R10 R13
         else if (next_state == st_sr_low)
            enter_pending <= 1'b0;
         // Exit owes a CBR before any access
         if (state == st_sr_high && next_state == st_idle)
            exit_pending <= 1'b1; // R11 R12
         else if (cbr_start)
            exit_pending <= 1'b0;
      end
   end

   // Request pin: low with the first slow pulse, high again before the exit CBR
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         sr_mode <= 1'b0;
      else if (next_state == st_sr_low && state == st_precharge)
         sr_mode <= 1'b1; // R1
      else if (state == st_sr_high && next_state == st_idle)
         sr_mode <= 1'b0; // R18
   end

   // Entry settle status follows the device delay
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst || !sr_mode)
         o_sr_settled <= 1'b0;
      else if (settle_tick)
         o_sr_settled <= 1'b1; // R5
   end

   // Latched access request
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         acc_we <= 1'b0;
         acc_col <= '0;
         acc_wdata <= 1'b0;
      end
      else if (accept)
      begin
         acc_we <= i_acc_we;
         acc_col <= i_acc_col;
         acc_wdata <= i_acc_wdata;
      end
   end

   // Read data and done pulse; data is raw, checking is left to the user
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         o_acc_done <= 1'b0;
         o_acc_rdata <= 1'b0;
      end
      else
      begin
         o_acc_done <= acc_end;
         if (acc_end && !acc_we)
            o_acc_rdata <= i_dout; // R17
      end
   end

   // Registered pins from the next phase; CBR drives no address
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         o_ras_n <= 1'b1;
         o_cas_n <= 1'b1;
         o_we_n <= 1'b1;
         o_addr <= '0;
         o_din <= 1'b0;
         o_self_refresh_request_n <= 1'b1;
      end
      else
      begin
         o_ras_n <= !ras_low_next;
         o_cas_n <= !cas_low_next;
         o_we_n <= !((next_state == st_acc_col) && acc_we);
         if (accept)
            o_addr <= i_acc_row;
         else if (next_state == st_acc_col && state == st_acc_row)
            o_addr <= acc_col;
         else if (next_state == st_cbr_cas)
            o_addr <= '0; // R8
         o_din <= acc_wdata;
         o_self_refresh_request_n <= !(sr_mode || (next_state == st_sr_low)); // R1 R18
      end
   end

   // Normal-mode refresh spacing, restarted by every CBR
   dps_interval #(.PERIOD(`DPS_REF_INT_CNT)) u_ref_timer
   (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_restart(cbr_start || sr_mode),
      .o_tick(ref_tick)
   );

   // Entry settle timer, held while not in self-refresh
   dps_interval #(.PERIOD(ENTRY_DLY_CNT)) u_settle_timer
   (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_restart(!sr_mode),
      .o_tick(settle_tick)
   );

   // Helper counters: cycles since the last refresh-type row strobe fall
   localparam int SR_MAX = `DPS_SR_CYC_MAX_CNT;
   localparam int REF_MAX = `DPS_REF_INT_CNT + 64;
   logic [15:0] since_fall;
   logic ras_q;
   wire ras_fall = ras_q && !o_ras_n;
   wire cbr_fall = ras_fall && !o_cas_n;
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         ras_q <= 1'b1;
         since_fall <= '0;
      end
      else
      begin
         ras_q <= o_ras_n;
         if (ras_fall && (cbr_fall || !o_self_refresh_request_n))
            since_fall <= '0;
         else if (since_fall != 16'hFFFF)
            since_fall <= since_fall + 16'h0001;
      end
   end

   sr_gap_max_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // R6
      !o_self_refresh_request_n |-> since_fall <= 16'(SR_MAX))
      else $error("self-refresh strobe gap too long");
   entry_gap_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // R13
      $fell(o_self_refresh_request_n) |-> ras_fall && $past(since_fall) <= 16'(SR_MAX))
      else $error("entry gap from last CBR too long");
   exit_cbr_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // R12
      $rose(o_self_refresh_request_n) |-> ##[1:8] cbr_fall)
      else $error("no CBR soon after self-refresh exit");
   // Exit CBR is the only CBR fall seen with the request still low four edges back
   exit_gap_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // R11
      cbr_fall && !$past(o_self_refresh_request_n, 4) |-> $past(since_fall) <= 16'(SR_MAX))
      else $error("exit gap to first CBR too long");
   cbr_req_high_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // R18
      cbr_fall |-> o_self_refresh_request_n)
      else $error("CBR issued with request low");
   normal_ref_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // R7
      o_self_refresh_request_n |-> since_fall <= 16'(REF_MAX))
      else $error("normal refresh interval exceeded");
   no_access_sr_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // R1
      !o_self_refresh_request_n |-> o_cas_n && o_we_n && !o_acc_ready)
      else $error("access activity during self-refresh");
   sr_pulse_width_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // R6
      ras_fall && !o_self_refresh_request_n |-> !o_ras_n [*8])
      else $error("self-refresh strobe pulse too short");
   no_ras_only_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // R14
      ras_fall && o_self_refresh_request_n && !(state == st_acc_row) |-> !o_cas_n)
      else $error("RAS-only cycle issued");
   done_pulse_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      o_acc_done |=> !o_acc_done)
      else $error("done longer than one cycle");

   sr_entry_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      $fell(o_self_refresh_request_n));
   sr_exit_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      $rose(o_self_refresh_request_n) ##[1:8] cbr_fall);
   access_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      accept ##[1:60] o_acc_done);
   settled_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      $rose(o_sr_settled));
endmodule // dps_ctrl

// >>> dps_dram_model.sv
// Behavioural model of the pulse self-refresh DRAM seen from its pins
`timescale 1ns/1ps
`include "dps_defines.svh"
module dps_dram_model
#(
   parameter int ENTRY = 50
)
(
   input wire logic i_ref_clk,
   input wire logic i_ras_n,
   input wire logic i_cas_n,
   input wire logic i_we_n,
   input wire logic [`DPS_ADDR_W-1:0] i_addr,
   input wire logic i_din,
   input wire logic i_self_refresh_request_n,
   output logic o_dout,
   output logic [15:0] o_rows
);
   logic mem [0:63];
   logic [2:0] row = 3'h0;
   logic [2:0] col = 3'h0;
   logic p_ras = 1'b1;
   logic p_cas = 1'b1;
   logic p_req = 1'b1;
   logic last = 1'b0;
   int div = 0;
   int dly = 0;
   initial o_rows = 16'h0000;
   // Pins sampled on the host clock; the part itself has no clock
   always @(posedge i_ref_clk)
   begin
      if (p_req && !i_self_refresh_request_n)
      begin
         div = 0;
         dly = 0;
      end
      else if (!i_self_refresh_request_n && dly < ENTRY)
         dly++;
      if (p_ras && !i_ras_n)
      begin
         if (!i_self_refresh_request_n)
         begin
            // Only the row divider runs here; all else sleeps
            if (dly >= ENTRY)
            begin
               if (div == 18)
               begin
                  div = 0;
                  o_rows <= o_rows + 16'h0001;
               end
               else
                  div++;
            end
         end
         else if (!i_cas_n)
            o_rows <= o_rows + 16'h0001;
         else
            row = i_addr[2:0];
      end
      // Plain storage, no parity or checking of any kind
      if (p_cas && !i_cas_n && !i_ras_n && i_self_refresh_request_n)
      begin
         col = i_addr[2:0];
         if (!i_we_n)
            mem[{row, col}] = i_din;
      end
      p_ras = i_ras_n;
      p_cas = i_cas_n;
      p_req = i_self_refresh_request_n;
   end
   // Released data line shows the inverse of its last value
   always_comb
   begin
      if (!i_ras_n && !i_cas_n && i_we_n && i_self_refresh_request_n)
         o_dout = mem[{row, i_addr[2:0]}];
      else
         o_dout = ~last;
   end
   always @(posedge i_ref_clk) last <= o_dout;
endmodule // dps_dram_model

// >>> tb_dps_ctrl.sv
// Self-checking bench for the pulse self-refresh controller
`timescale 1ns/1ps
`include "dps_defines.svh"
module tb_dps_ctrl;
   import dps_pkg::*;
   localparam int ENTRY = 50;
   logic clk, rst, sleep, req, we, wd;
   logic [`DPS_ADDR_W-1:0] row, col, addr;
   logic ready, done, rdata, act, settled, ras_n, cas_n, we_n, din, dout, req_n;
   logic [15:0] rows;
   int mismatches = 0;
   int num_checks = 0;
   int cyc = 0;
   int last_fall, prev_fall, last_cbr, cbr_n, sr_falls, gap_sr, req_fall, req_rise;
   logic p_ras = 1'b1;
   logic p_req = 1'b1;
   dps_ctrl #(.ENTRY_DLY_CNT(ENTRY)) u_dut (.i_ref_clk(clk), .i_sys_rst(rst),
      .i_sleep_req(sleep), .i_acc_req(req), .i_acc_we(we), .i_acc_row(row),
      .i_acc_col(col), .i_acc_wdata(wd), .i_dout(dout), .o_acc_ready(ready),
      .o_acc_done(done), .o_acc_rdata(rdata), .o_sr_active(act), .o_sr_settled(settled),
      .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_addr(addr), .o_din(din),
      .o_self_refresh_request_n(req_n));
   dps_dram_model #(.ENTRY(ENTRY)) u_mem (.i_ref_clk(clk), .i_ras_n(ras_n),
      .i_cas_n(cas_n), .i_we_n(we_n), .i_addr(addr), .i_din(din),
      .i_self_refresh_request_n(req_n), .o_dout(dout), .o_rows(rows));
   // Clock at 25 ns
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) cyc++;
   // Strobe watcher: row strobe falls, their kind and request edges
   always @(negedge clk)
   begin
      if (p_ras && !ras_n)
      begin
         if (!req_n)
         begin
            sr_falls++;
            gap_sr = cyc - last_fall;
         end
         else if (!cas_n)
         begin
            cbr_n++;
            last_cbr = cyc;
         end
         prev_fall = last_fall;
         last_fall = cyc;
      end
      if (p_req && !req_n)
         req_fall = cyc;
      if (!p_req && req_n)
         req_rise = cyc;
      p_ras = ras_n;
      p_req = req_n;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Quiet pins straight after reset
   task automatic t_reset();
      check({ras_n, cas_n, we_n, req_n, done, settled, act, ready}, 32'h0000_00F1);
      check(addr, 32'h0000_0000);
   endtask
   // One access; done lands 26 cycles after the accepting edge
   task automatic t_access(input logic w, input int r, input int c, input logic d);
      int k;
      k = 0;
      while (!ready && k < 200)
      begin
         @(negedge clk);
         k++;
      end
      req = 1'b1;
      we = w;
      row = r[`DPS_ADDR_W-1:0];
      col = c[`DPS_ADDR_W-1:0];
      wd = d;
      @(posedge clk);
      @(negedge clk);
      req = 1'b0;
      k = 1;
      while (!done && k < 100)
      begin
         @(negedge clk);
         k++;
      end
      check(k, 27);
      if (!w)
         check(rdata, d);
   endtask
   // Periodic refresh is CAS before RAS and spaced within 2527 cycles
   task automatic t_refresh();
      int n, t0, r0, k;
      n = cbr_n;
      k = 0;
      while (cbr_n == n && k < 3000)
      begin
         @(negedge clk);
         k++;
      end
      // Let the model count the row before sampling it
      @(negedge clk);
      t0 = last_cbr;
      r0 = rows;
      k = 0;
      while (cbr_n == n + 1 && k < 3000)
      begin
         @(negedge clk);
         k++;
      end
      @(negedge clk);
      check(last_cbr - t0 <= 2527, 1);
      check(rows, r0 + 1);
   endtask
   // Entry: request low with slow strobe pulses, refused accesses
   task automatic t_sleep();
      int k, r0;
      sleep = 1'b1;
      k = 0;
      while (req_n && k < 3000)
      begin
         @(negedge clk);
         k++;
      end
      // One more edge so the strobe watcher has surely run
      @(negedge clk);
      r0 = rows;
      check(last_fall, req_fall);
      check(last_fall - prev_fall <= 200, 1);
      check({act, ready}, 32'h0000_0002);
      while (!settled && k < 4000)
      begin
         @(negedge clk);
         k++;
      end
      check((cyc - req_fall >= ENTRY) && (cyc - req_fall <= ENTRY + 1), 1);
      // Twentieth slow pulse completes the first divided row refresh
      while (sr_falls < 20 && k < 8000)
      begin
         @(negedge clk);
         k++;
      end
      @(negedge clk);
      check(gap_sr, 160);
      check(req_n, 1'b0);
      check(rows, r0 + 1);
   endtask
   // Exit: request back high, then a CBR well inside the cycle maximum
   task automatic t_wake();
      int n, k, r0;
      n = cbr_n;
      r0 = rows;
      sleep = 1'b0;
      k = 0;
      while (cbr_n == n && k < 500)
      begin
         @(negedge clk);
         k++;
      end
      @(negedge clk);
      check(req_rise < last_cbr, 1);
      check(last_cbr - prev_fall <= 200, 1);
      check(last_cbr - req_rise <= 200, 1);
      check(rows, r0 + 1);
      t_access(1'b0, 5, 3, 1'b1);
   endtask
   // Inputs move on the falling edge only
   initial
   begin
      {sleep, req, we, wd} = 4'h0;
      row = '0;
      col = '0;
      {last_fall, prev_fall, last_cbr, cbr_n, sr_falls, gap_sr, req_fall, req_rise} = '0;
      rst = 1'b1;
      // Seventeen rising edges inside reset
      repeat (17) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_access(1'b1, 5, 3, 1'b1);
      t_access(1'b1, 2, 6, 1'b0);
      t_access(1'b0, 5, 3, 1'b1);
      t_access(1'b0, 2, 6, 1'b0);
      t_refresh();
      t_sleep();
      t_wake();
      test_done();
   end
   // Hang guard, well past the expected run length
   initial
   begin
      #(25 * 40000);
      mismatches++;
      test_done();
   end
endmodule // tb_dps_ctrl
